// *** design/mqfs_params.svh ***
/*
  Constants of the multi-queue flag and status block: sizes, address fields,
  register offsets, reset values and pipeline depths.
  Assumes it is included by bare name, after the package, in every design file.
*/
`ifndef MQFS_PARAMS_SVH
`define MQFS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define MQFS_NQ         32
`define MQFS_QUAD_W     8
`define MQFS_QSEL_W     2
`define MQFS_QUEUE_W    5
`define MQFS_ID_W       3
`define MQFS_ADDR_W     8
`define MQFS_LVL_W      12

// ----------------------------------------------------------------------------
// Queue address fields: device id on top, quadrant inside the queue field
// ----------------------------------------------------------------------------
`define MQFS_ID_LSB     5
`define MQFS_QUAD_LSB   3

// ----------------------------------------------------------------------------
// Register offsets (byte addresses) and reset values
// ----------------------------------------------------------------------------
`define MQFS_OFS_CTRL   4'h0
`define MQFS_OFS_STAT   4'h4
`define MQFS_AE_THR_RST 12'h008
`define MQFS_AF_THR_RST 12'h3f8
`define MQFS_RDATA_RST  32'h0000_0000

// ----------------------------------------------------------------------------
// Flag levels and timing
// ----------------------------------------------------------------------------
`define MQFS_OV_DELAY   2
`define MQFS_FLAG_IDLE  1'b1
`define MQFS_BUS_IDLE   8'hff
`define MQFS_QUAD_LAST  2'h3
`define MQFS_QUAD_FIRST 2'h0
`define MQFS_QUAD_STEP  2'h1

`endif

// *** design/mqfs_pkg.sv ***
/*
  Types of the multi-queue flag and status block: bus carriers, strap group,
  register layouts, modes and the packed state of each module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mqfs_pkg;

  // --------------------------------------------------------------------------
  // Modes and states
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    MQFS_DIRECT = 1'b0,
    MQFS_POLLED = 1'b1
  } mqfs_bus_mode_t;

  // Encoded so that the state bit is waitrequest itself
  typedef enum logic [0:0] {
    MQFS_AV_ACK  = 1'b0,
    MQFS_AV_IDLE = 1'b1
  } mqfs_av_state_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } mqfs_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } mqfs_av_rsp_t;

  typedef struct packed {
    logic       output_width_strap;
    logic       input_width_strap;
    logic       bus_matching_strap;
    logic       packet_mode_strap;
    logic       flag_bus_mode;
    logic [2:0] device_id;
  } mqfs_strap_t;

  // --------------------------------------------------------------------------
  // Register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  rsv1;
    logic [11:0] af_thr;
    logic [3:0]  rsv0;
    logic [11:0] ae_thr;
  } mqfs_ctrl_t;

  typedef struct packed {
    logic [7:0]  rsv;
    logic [4:0]  wq;
    logic [4:0]  rq;
    logic [1:0]  quad;
    logic        pr;
    logic        af;
    logic        ae;
    logic        ov;
    mqfs_strap_t straps;
  } mqfs_status_t;

  // --------------------------------------------------------------------------
  // Module state
  // --------------------------------------------------------------------------
  typedef struct packed {
    mqfs_strap_t    straps;
    mqfs_ctrl_t     ctrl;
    mqfs_av_state_t av_st;
    logic [31:0]    rdata;
    logic [4:0]     rq;
    logic           rd_match;
    logic [4:0]     wq;
    logic           wr_match;
    logic           ae;
    logic           pr;
    logic           af;
    logic           ov_oe;
    logic [1:0]     quad;
    logic           bus_oe;
  } mqfs_top_state_t;

  typedef struct packed {
    logic stage;
    logic ov;
  } mqfs_ov_state_t;

  typedef struct packed {
    logic [7:0] data;
  } mqfs_mux_state_t;

endpackage : mqfs_pkg

// *** design/mqfs_ov_pipe.sv ***
/*
  Output-valid flag pipeline: delays the selected queue's data-present level
  so the flag lines up with the two-stage read data path.
  Assumes the caller picks the selected queue's level combinationally.
*/
`timescale 1ns/100ps
`include "mqfs_params.svh"

module mqfs_ov_pipe
  import mqfs_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic nonempty_i,
  output logic      ov_o
);

  mqfs_ov_state_t st;
  mqfs_ov_state_t next_st;

  // --------------------------------------------------------------------------
  // Two flops: one stage plus the flag itself
  // --------------------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.stage = nonempty_i;
    next_st.ov    = ~st.stage;  // High when no valid word
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '{stage: 1'b0, ov: `MQFS_FLAG_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign ov_o = st.ov;

endmodule : mqfs_ov_pipe

// *** design/mqfs_quad_mux.sv ***
/*
  Quadrant selector of the status bus: registers the eight flags of one
  quadrant out of the per-queue flag vector.
  Assumes the flag vector is already active low.
*/
`timescale 1ns/100ps
`include "mqfs_params.svh"

module mqfs_quad_mux
  import mqfs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [31:0] flags_i,
  input  wire logic [1:0]  quad_i,
  output logic      [7:0]  data_o
);

  mqfs_mux_state_t st;
  mqfs_mux_state_t next_st;

  function automatic logic [7:0] pick(input logic [31:0] v, input logic [1:0] q);
    pick = v[q*`MQFS_QUAD_W +: `MQFS_QUAD_W];
  endfunction : pick

  always_comb begin
    next_st      = st;
    next_st.data = pick(flags_i, quad_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '{data: `MQFS_BUS_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.data;

endmodule : mqfs_quad_mux

// *** design/mqfs_flags.sv ***
/*
  Flag and status outputs of a multi-queue FIFO: output-valid, discrete
  almost-empty, packet-ready and almost-full flags, and the 8-bit
  empty/packet status bus in direct or polled mode, with an Avalon-MM slave
  for thresholds and status.
  Assumes read and write ports share core_clk_i, reset_i is the master
  reset, and the queue core supplies per-queue levels and fill counts.
*/
`timescale 1ns/100ps
`include "mqfs_params.svh"

// Notes on behaviour
// - Valid flag trails queue selection two cycles
// - Empty selected queue drives valid flag high
// - Valid flag has its own output enable
// - Almost-empty low for almost-empty read queue
// - Almost-empty flag updated on read clock
// - Status bus shows one of four quadrants
// - Packet mode latched at reset selects content
// - Bus mode latched at reset, direct/polled
// - Status bus has its own output enable
// - Direct mode: strobe and address pick quadrant
// - Polled mode steps quadrant every clock
// - Almost-full low for almost-full write queue
// - Almost-full flag updated on write clock
// - Packet-ready low when complete packet held
module mqfs_flags
  import mqfs_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire mqfs_av_req_t             av_req_i,
  output mqfs_av_rsp_t                  av_rsp_o,
  input  wire mqfs_strap_t              straps_i,
  input  wire logic [`MQFS_ADDR_W-1:0]  read_queue_address_i,
  input  wire logic                     read_address_strobe_i,
  input  wire logic                     empty_bus_strobe_i,
  input  wire logic [`MQFS_ADDR_W-1:0]  write_queue_address_i,
  input  wire logic                     write_address_strobe_i,
  input  wire logic [`MQFS_NQ-1:0]      queue_nonempty_i,
  input  wire logic [`MQFS_NQ-1:0]      queue_almost_empty_i,
  input  wire logic [`MQFS_NQ-1:0]      queue_packet_ready_i,
  input  wire logic [`MQFS_LVL_W-1:0]   read_fill_level_i,
  input  wire logic [`MQFS_LVL_W-1:0]   write_fill_level_i,
  output logic                          output_valid_flag_o,
  output logic                          output_valid_flag_oe_o,
  output logic                          almost_empty_flag_o,
  output logic                          packet_ready_flag_o,
  output logic                          almost_full_flag_o,
  output logic [`MQFS_QUAD_W-1:0]       empty_packet_status_bus_o,
  output logic                          empty_packet_status_bus_oe_o
);

  mqfs_top_state_t st;
  mqfs_top_state_t next_st;
  logic            nonempty_sel;
  logic [31:0]     bus_flags;
  logic            ov_flag;
  logic [7:0]      bus_data;
  mqfs_status_t    status;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic id_hit(input logic [7:0] a, input logic [2:0] id);
    id_hit = (a[`MQFS_ADDR_W-1:`MQFS_ID_LSB] == id);
  endfunction : id_hit

  function automatic logic [4:0] queue_of(input logic [7:0] a);
    queue_of = a[`MQFS_ID_LSB-1:0];
  endfunction : queue_of

  function automatic logic [1:0] quad_of(input logic [7:0] a);
    quad_of = a[`MQFS_ID_LSB-1:`MQFS_QUAD_LSB];
  endfunction : quad_of

  function automatic logic polled(input mqfs_strap_t s);
    polled = (mqfs_bus_mode_t'(s.flag_bus_mode) == MQFS_POLLED);
  endfunction : polled

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  always_comb begin
    status        = '0;
    status.straps = st.straps;
    status.ov     = output_valid_flag_o;
    status.ae     = st.ae;
    status.af     = st.af;
    status.pr     = st.pr;
    status.quad   = st.quad;
    status.rq     = st.rq;
    status.wq     = st.wq;
  end

  assign nonempty_sel = queue_nonempty_i[st.rq];
  // Active low on the bus; content picked by the latched packet strap
  assign bus_flags    = st.straps.packet_mode_strap ? ~queue_packet_ready_i
                                                    : ~queue_almost_empty_i;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // Avalon slave: one wait cycle, then a one-cycle answer
    unique case (st.av_st)
      MQFS_AV_IDLE: begin
        if (av_req_i.read || av_req_i.write) begin
          next_st.av_st = MQFS_AV_ACK;
          unique case (av_req_i.address)
            `MQFS_OFS_CTRL: next_st.rdata = st.ctrl;
            `MQFS_OFS_STAT: next_st.rdata = status;
            default:        next_st.rdata = `MQFS_RDATA_RST;
          endcase
        end
      end
      MQFS_AV_ACK: begin
        next_st.av_st = MQFS_AV_IDLE;
        if (av_req_i.write && av_req_i.address == `MQFS_OFS_CTRL) begin
          next_st.ctrl      = av_req_i.writedata;
          next_st.ctrl.rsv0 = '0;
          next_st.ctrl.rsv1 = '0;
        end
      end
    endcase

    // Read-port queue selection
    if (read_address_strobe_i) begin
      next_st.rq       = queue_of(read_queue_address_i);
      next_st.rd_match = id_hit(read_queue_address_i, st.straps.device_id);
    end
    next_st.ov_oe = st.rd_match;  // Drive only while this device is read-selected

    // Write-port queue selection
    if (write_address_strobe_i) begin
      next_st.wq       = queue_of(write_queue_address_i);
      next_st.wr_match = id_hit(write_queue_address_i, st.straps.device_id);
    end

    // Discrete flags, active low, re-evaluated every clock
    next_st.ae = ~(read_fill_level_i <= st.ctrl.ae_thr);
    // Almost-full on the write-selected queue
    next_st.af = ~(write_fill_level_i >= st.ctrl.af_thr);
    // Complete packet held by the read queue
    next_st.pr = ~(st.straps.packet_mode_strap && queue_packet_ready_i[st.rq]);

    // Status bus quadrant
    if (polled(st.straps)) begin
      next_st.bus_oe = 1'b1;
      if (st.quad == `MQFS_QUAD_LAST) begin
        next_st.quad = `MQFS_QUAD_FIRST;
      end else begin
        next_st.quad = st.quad + `MQFS_QUAD_STEP;
      end
    end else if (empty_bus_strobe_i) begin
      next_st.quad   = quad_of(read_queue_address_i);
      next_st.bus_oe = id_hit(read_queue_address_i, st.straps.device_id);
    end
  end

  // --------------------------------------------------------------------------
  // State register; straps caught while the master reset is held
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st          <= '0;
      st.straps   <= straps_i;  // Latched modes
      st.ctrl     <= '{rsv1: 4'h0, af_thr: `MQFS_AF_THR_RST,
                       rsv0: 4'h0, ae_thr: `MQFS_AE_THR_RST};
      st.av_st    <= MQFS_AV_IDLE;
      st.rdata    <= `MQFS_RDATA_RST;
      st.ae       <= `MQFS_FLAG_IDLE;
      st.pr       <= `MQFS_FLAG_IDLE;
      st.af       <= `MQFS_FLAG_IDLE;
      st.quad     <= `MQFS_QUAD_FIRST;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  mqfs_ov_pipe u_ov_pipe (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .nonempty_i (nonempty_sel),
    .ov_o       (ov_flag)
  );

  mqfs_quad_mux u_quad_mux (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .flags_i    (bus_flags),
    .quad_i     (next_st.quad),  // Data and quadrant change on the same edge
    .data_o     (bus_data)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign av_rsp_o.readdata            = st.rdata;
  assign av_rsp_o.waitrequest         = st.av_st;
  assign output_valid_flag_o          = ov_flag;
  assign output_valid_flag_oe_o       = st.ov_oe;
  assign almost_empty_flag_o          = st.ae;
  assign packet_ready_flag_o          = st.pr;
  assign almost_full_flag_o           = st.af;
  assign empty_packet_status_bus_o    = bus_data;
  assign empty_packet_status_bus_oe_o = st.bus_oe;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  ov_delay_a: assert property (
    !$past(reset_i, 1) && !$past(reset_i, 2) |-> output_valid_flag_o == !$past(nonempty_sel, 2))
    else $error("valid flag not two cycles behind selected queue");

  ov_empty_a: assert property (
    !nonempty_sel ##1 !nonempty_sel |=> output_valid_flag_o)
    else $error("valid flag low although queue empty");

  ov_enable_a: assert property (
    output_valid_flag_oe_o == $past(st.rd_match))
    else $error("valid flag enable not following read selection");

  rd_pick_a: assert property (
    read_address_strobe_i
      |=> st.rd_match == $past(id_hit(read_queue_address_i, st.straps.device_id)))
    else $error("read selection id not taken");

  sel_take_a: assert property (
    read_address_strobe_i |=> st.rq == $past(queue_of(read_queue_address_i)))
    else $error("read queue not taken");

  sel_hold_a: assert property (
    !read_address_strobe_i |=> $stable(st.rq))
    else $error("read queue moved without strobe");

  // --------------------------------------------------------------------------
  // Discrete flags and write-port selection
  // --------------------------------------------------------------------------

  ae_set_a: assert property (
    read_fill_level_i <= st.ctrl.ae_thr |=> !almost_empty_flag_o)
    else $error("almost-empty flag not low");

  ae_release_a: assert property (
    read_fill_level_i > st.ctrl.ae_thr |=> almost_empty_flag_o)
    else $error("almost-empty flag not released");

  af_set_a: assert property (
    write_fill_level_i >= st.ctrl.af_thr |=> !almost_full_flag_o)
    else $error("almost-full flag not low");

  af_release_a: assert property (
    write_fill_level_i < st.ctrl.af_thr |=> almost_full_flag_o)
    else $error("almost-full flag not released");

  wsel_take_a: assert property (
    write_address_strobe_i |=> st.wq == $past(queue_of(write_queue_address_i)))
    else $error("write queue not taken");

  wr_pick_a: assert property (
    write_address_strobe_i
      |=> st.wr_match == $past(id_hit(write_queue_address_i, st.straps.device_id)))
    else $error("write selection id not taken");

  // --------------------------------------------------------------------------
  // Status bus, packet flag and register bus
  // --------------------------------------------------------------------------

  mode_hold_a: assert property (
    !$past(reset_i) |-> $stable(st.straps))
    else $error("latched modes changed outside reset");

  poll_step_a: assert property (
    polled(st.straps) && st.quad != `MQFS_QUAD_LAST |=> st.quad == $past(st.quad) + 2'h1)
    else $error("polled quadrant did not step");

  poll_wrap_a: assert property (
    polled(st.straps) && st.quad == `MQFS_QUAD_LAST |=> st.quad == `MQFS_QUAD_FIRST)
    else $error("polled quadrant did not wrap");

  direct_pick_a: assert property (
    !polled(st.straps) && empty_bus_strobe_i
      |=> st.quad == $past(read_queue_address_i[4:3])
       && empty_packet_status_bus_oe_o == $past(read_queue_address_i[7:5] == st.straps.device_id))
    else $error("direct quadrant selection missed");

  bus_content_a: assert property (
    !$past(reset_i)
      |-> empty_packet_status_bus_o == 8'($past(bus_flags) >> (st.quad * `MQFS_QUAD_W)))
    else $error("status bus shows wrong quadrant content");

  poll_drive_a: assert property (
    polled(st.straps) |=> empty_packet_status_bus_oe_o)
    else $error("polled bus not driven");

  direct_hold_a: assert property (
    !polled(st.straps) && !empty_bus_strobe_i
      |=> $stable(st.quad) && $stable(empty_packet_status_bus_oe_o))
    else $error("direct quadrant moved without strobe");

  pr_flag_a: assert property (
    st.straps.packet_mode_strap && queue_packet_ready_i[st.rq] |=> !packet_ready_flag_o)
    else $error("packet-ready flag not low");

  pr_idle_a: assert property (
    !st.straps.packet_mode_strap |=> packet_ready_flag_o)
    else $error("packet-ready flag low outside packet mode");

  pr_release_a: assert property (
    !queue_packet_ready_i[st.rq] |=> packet_ready_flag_o)
    else $error("packet-ready flag low without packet");

  av_answer_a: assert property (
    av_rsp_o.waitrequest && (av_req_i.read || av_req_i.write)
      |=> !av_rsp_o.waitrequest ##1 av_rsp_o.waitrequest)
    else $error("bus answer not one cycle after wait");

  av_quiet_a: assert property (
    av_rsp_o.waitrequest && !av_req_i.read && !av_req_i.write |=> av_rsp_o.waitrequest)
    else $error("bus answered without request");

  av_single_a: assert property (
    !av_rsp_o.waitrequest |=> av_rsp_o.waitrequest)
    else $error("bus answer longer than one cycle");

  ctrl_keep_a: assert property (
    !(av_req_i.write && !av_rsp_o.waitrequest && av_req_i.address == `MQFS_OFS_CTRL)
      |=> $stable(st.ctrl))
    else $error("thresholds changed without write");

endmodule : mqfs_flags

// *** testbench/mqfs_ctrl_model.sv ***
/*
  Controller and queue-core model beside the flag block: drives the straps
  and the fill levels of the queues that it has selected itself.
  Assumes the bench writes lvl[] and changes modes only inside reset.
*/
`timescale 1ns/100ps

module mqfs_ctrl_model
  import mqfs_pkg::*;
#(
  parameter logic [2:0] DEV_ID = 3'h0,
  parameter logic       WIDE   = 1'b1
)
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        packet_mode_i,
  input  wire logic        polled_i,
  input  wire logic [7:0]  read_queue_address_i,
  input  wire logic        read_address_strobe_i,
  input  wire logic [7:0]  write_queue_address_i,
  input  wire logic        write_address_strobe_i,
  output mqfs_strap_t      straps_o,
  output logic      [11:0] read_fill_level_o,
  output logic      [11:0] write_fill_level_o
);
  logic [11:0] lvl [0:31];
  logic [4:0]  rq;
  logic [4:0]  wq;

  // ---------------------------------------------------------------------
  // Straps
  // ---------------------------------------------------------------------
  // Width straps fixed at both ports wide, so packet mode is legal
  assign straps_o = '{output_width_strap: WIDE, input_width_strap: WIDE,
                      bus_matching_strap: WIDE, packet_mode_strap: packet_mode_i,
                      flag_bus_mode: polled_i, device_id: DEV_ID};

  // ---------------------------------------------------------------------
  // Queue selection and levels
  // ---------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) begin
      lvl[i] = 12'h000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rq <= 5'h00;
      wq <= 5'h00;
    end else begin
      if (read_address_strobe_i && read_queue_address_i[7:5] == DEV_ID) begin
        rq <= read_queue_address_i[4:0];
      end
      if (write_address_strobe_i && write_queue_address_i[7:5] == DEV_ID) begin
        wq <= write_queue_address_i[4:0];
      end
    end
  end

  assign read_fill_level_o  = lvl[rq];
  assign write_fill_level_o = lvl[wq];
endmodule : mqfs_ctrl_model

// *** testbench/tb.sv ***
/*
  Self-checking bench of the flag block: Avalon register access, valid,
  discrete flags and the status bus in direct, packet and polled modes.
  Assumes the controller model drives straps and fill levels.
*/
`timescale 1ns/100ps
`include "mqfs_params.svh"

module tb
  import mqfs_pkg::*;
;
  logic         core_clk_i = 1'b0;
  logic         reset_i    = 1'b1;
  mqfs_av_req_t av_req     = '0;
  mqfs_av_rsp_t av_rsp;
  mqfs_strap_t  straps;
  logic [7:0]   rqa        = 8'h00;
  logic [7:0]   wqa        = 8'h00;
  logic         rstb       = 1'b0;
  logic         wstb       = 1'b0;
  logic         estb       = 1'b0;
  logic         pkt        = 1'b0;
  logic         pol        = 1'b0;
  logic [31:0]  ne         = 32'h0000_0000;
  logic [31:0]  aev        = 32'h8c4a_e153;
  logic [31:0]  prv        = 32'h0000_0000;
  logic [11:0]  rlvl;
  logic [11:0]  wlvl;
  logic         ov;
  logic         ov_oe;
  logic         ae;
  logic         pr;
  logic         af;
  logic         bus_oe;
  logic [7:0]   bus;
  logic [31:0]  rd;
  int           n_fail     = 0;
  int           n_compared = 0;

  always #50 core_clk_i = ~core_clk_i;

  mqfs_ctrl_model partner (.core_clk_i(core_clk_i), .reset_i(reset_i), .packet_mode_i(pkt),
    .polled_i(pol), .read_queue_address_i(rqa), .read_address_strobe_i(rstb),
    .write_queue_address_i(wqa), .write_address_strobe_i(wstb), .straps_o(straps),
    .read_fill_level_o(rlvl), .write_fill_level_o(wlvl));

  mqfs_flags DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .av_req_i(av_req),
    .av_rsp_o(av_rsp), .straps_i(straps), .read_queue_address_i(rqa),
    .read_address_strobe_i(rstb), .empty_bus_strobe_i(estb), .write_queue_address_i(wqa),
    .write_address_strobe_i(wstb), .queue_nonempty_i(ne), .queue_almost_empty_i(aev),
    .queue_packet_ready_i(prv), .read_fill_level_i(rlvl), .write_fill_level_i(wlvl),
    .output_valid_flag_o(ov), .output_valid_flag_oe_o(ov_oe), .almost_empty_flag_o(ae),
    .packet_ready_flag_o(pr), .almost_full_flag_o(af), .empty_packet_status_bus_o(bus),
    .empty_packet_status_bus_oe_o(bus_oe));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : step

  task automatic test_done;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Hold the request until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    av_req <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge core_clk_i);
    end while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    av_req <= '0;
  endtask : av

  // Modes: 0 read select, 1 write select, 2 status bus quadrant select
  task automatic sel(input int m, input logic [7:0] a);
    @(posedge core_clk_i);
    rqa  <= (m == 1) ? rqa : a;
    wqa  <= (m == 1) ? a : wqa;
    rstb <= (m == 0);
    wstb <= (m == 1);
    estb <= (m == 2);
    @(posedge core_clk_i);
    rstb <= 1'b0;
    wstb <= 1'b0;
    estb <= 1'b0;
  endtask : sel

  // Strap changes only while reset is held
  task automatic do_reset(input logic p, input logic f);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    pkt     <= p;
    pol     <= f;
    step(12);
    check({ov, ov_oe, ae, af, pr, bus_oe, bus, av_rsp.waitrequest}, {6'b101110, 8'hff, 1'b1});
    reset_i <= 1'b0;
  endtask : do_reset

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_fail++;
    test_done();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    av(1'b0, 4'h0, 32'h0);
    check(rd, 32'h03f8_0008);
    av(1'b1, 4'h0, 32'hf200_f010);
    av(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0200_0010);
    av(1'b1, 4'h8, 32'hffff_ffff);
    av(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    av(1'b1, 4'h4, 32'hffff_ffff);
    av(1'b0, 4'h4, 32'h0);
    check(rd[7:0], straps);
    // Valid flag trails the selection by two cycles
    ne <= 32'h0000_0020;
    sel(0, 8'h05);
    step(2);
    check(ov, 1'b1);
    step(1);
    check(ov, 1'b0);
    check(ov_oe, 1'b1);
    ne <= 32'h0;
    step(2);
    check(ov, 1'b0);
    step(1);
    check(ov, 1'b1);
    sel(0, 8'h25);
    step(3);
    check(ov_oe, 1'b0);
    sel(0, 8'h05);
    partner.lvl[5] <= 12'h011;
    step(3);
    check(ae, 1'b1);
    partner.lvl[5] <= 12'h010;
    step(2);
    check(ae, 1'b0);
    sel(1, 8'h07);
    partner.lvl[7] <= 12'h200;
    step(3);
    check(af, 1'b0);
    partner.lvl[7] <= 12'h1ff;
    step(2);
    check(af, 1'b1);
    check(pr, 1'b1);
    for (int q = 0; q < 4; q++) begin
      sel(2, 8'(q * 8));
      step(2);
      check({bus_oe, bus}, {1'b1, ~aev[8*q +: 8]});
    end
    sel(2, 8'h28);
    step(2);
    check(bus_oe, 1'b0);
    // Packet mode
    do_reset(1'b1, 1'b0);
    prv <= 32'h0000_0400;
    sel(0, 8'h0a);
    step(3);
    check(pr, 1'b0);
    sel(0, 8'h0b);
    step(3);
    check(pr, 1'b1);
    sel(2, 8'h08);
    step(2);
    check(bus, {~prv[15:8]});
    // Polled mode: find quadrant 0, then follow the stepping
    do_reset(1'b0, 1'b1);
    for (int k = 0; k < 8 && bus !== ~aev[7:0]; k++) begin
      step(1);
    end
    for (int i = 1; i < 6; i++) begin
      step(1);
      check({bus_oe, bus}, {1'b1, ~aev[8*(i%4) +: 8]});
    end
    test_done();
  end
endmodule : tb
